// ---- src/mis_motion_inhibit.sv ----
// Motion inhibit and status logic with a classic Wishbone register slave.
//
// The Wishbone interface to the registers and the register offsets were left to the implementer.
`default_nettype none

module mis_motion_inhibit #(
    parameter int NUM_AXES = mis_pkg::AXES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] adr_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    input wire logic we_i,
    input wire logic [3:0] sel_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    output logic ack_o,
    input wire logic [7:0] ctl_byte_i,
    input wire logic [2:0] mode_sel_i,
    input wire logic [NUM_AXES-1:0] axis_interlock_n_i,
    input wire logic [NUM_AXES-1:0] dir_interlock_plus_i,
    input wire logic [NUM_AXES-1:0] dir_interlock_minus_i,
    input wire logic [7:0] lathe_interlock_i,
    input wire logic [15:0] manual_override_n_i,
    input wire logic all_axis_machine_lock_i,
    input wire logic [NUM_AXES-1:0] per_axis_machine_lock_i,
    input wire logic [15:0] ext_diag_i,
    input wire logic [NUM_AXES*16-1:0] pos_err_i,
    input wire logic [NUM_AXES-1:0] move_req_i,
    input wire logic [NUM_AXES-1:0] move_plus_i,
    output logic emergency_status_indication_o,
    output logic reset_status_o,
    output logic rewind_request_o,
    output logic [4:0] mode_disp_o,
    output logic [NUM_AXES-1:0] permit_plus_o,
    output logic [NUM_AXES-1:0] permit_minus_o,
    output logic [15:0] diag_o,
    output logic [15:0] manual_override_o
);

    generate
        if (NUM_AXES < mis_pkg::LATHE_AXES || NUM_AXES > mis_pkg::AXES) begin : g_bad
            $error("NUM_AXES must lie between 2 and 4");
        end
    endgenerate

    // ==========================================================
    // Mode decoding.
    function automatic logic [4:0] mode_decode(input logic [2:0] code);
        logic [4:0] oh;
        oh = 5'h00;
        oh[mis_pkg::MD_JOG] = (code == mis_pkg::MODE_JOG);
        oh[mis_pkg::MD_HND] = (code == mis_pkg::MODE_HND);
        oh[mis_pkg::MD_MDI] = (code == mis_pkg::MODE_MDI);
        oh[mis_pkg::MD_MEM] = (code == mis_pkg::MODE_MEM);
        oh[mis_pkg::MD_EDIT] = (code == mis_pkg::MODE_EDIT);
        return oh;
    endfunction

    // ==========================================================
    // Pin synchronisers, two flip-flops each.
    logic [7:0] ctl_m, ctl_s;
    logic [2:0] mode_m, mode_s;
    logic [NUM_AXES-1:0] ilk_m, ilk_s;
    logic [NUM_AXES-1:0] dplus_m, dplus_s;
    logic [NUM_AXES-1:0] dminus_m, dminus_s;
    logic [7:0] lathe_m, lathe_s;
    logic [15:0] ovr_m, ovr_s;
    logic mlk_m, mlk_s;
    logic [NUM_AXES-1:0] per_axis_machine_lock_m, per_axis_machine_lock_s;

    always_ff @(posedge clk_i) begin
        ctl_m <= ctl_byte_i;
        ctl_s <= ctl_m;
        mode_m <= mode_sel_i;
        mode_s <= mode_m;
        ilk_m <= axis_interlock_n_i;
        ilk_s <= ilk_m;
        dplus_m <= dir_interlock_plus_i;
        dplus_s <= dplus_m;
        dminus_m <= dir_interlock_minus_i;
        dminus_s <= dminus_m;
        lathe_m <= lathe_interlock_i;
        lathe_s <= lathe_m;
        ovr_m <= manual_override_n_i;
        ovr_s <= ovr_m;
        mlk_m <= all_axis_machine_lock_i;
        mlk_s <= mlk_m;
        per_axis_machine_lock_m <= per_axis_machine_lock_i;
        per_axis_machine_lock_s <= per_axis_machine_lock_m;
    end

    // ==========================================================
    // Software registers.
    logic [7:0] cfg;
    logic [7:0] ctl;
    logic [15:0] inpw;

    // ==========================================================
    // Stop, reset and mode.
    wire esp_act = ~ctl_s[mis_pkg::BIT_ESP];
    wire ers_act = ctl_s[mis_pkg::BIT_ERS];
    wire rrw_act = ctl_s[mis_pkg::BIT_RRW];
    wire rkey_act = ctl[mis_pkg::CTL_RKEY];
    wire reset_act = ers_act | rrw_act | rkey_act;
    wire wait_rel = esp_act | ers_act | rrw_act;
    wire [4:0] mode_oh = mode_decode(mode_s);
    wire mode_valid = |mode_oh;
    wire manual = mode_oh[mis_pkg::MD_JOG] | mode_oh[mis_pkg::MD_HND];
    wire automatic_op = mode_oh[mis_pkg::MD_MDI] | mode_oh[mis_pkg::MD_MEM];
    wire lathe = ctl[mis_pkg::CTL_LATHE];

    // ==========================================================
    // Interlocks.
    wire glob_ilk = ~cfg[mis_pkg::CFG_ITL] & ~ctl_s[mis_pkg::BIT_IT];
    wire [NUM_AXES-1:0] axis_ilk = {NUM_AXES{~cfg[mis_pkg::CFG_ITX]}} & ~ilk_s;
    wire dir_en = ~cfg[mis_pkg::CFG_DIT];
    wire dir_apply = dir_en & ~lathe & (manual | (cfg[mis_pkg::CFG_DAU] & automatic_op));
    wire lathe_apply = dir_en & lathe & manual;
    logic [NUM_AXES-1:0] plus_blk, minus_blk;

    generate
        for (genvar n = 0; n < NUM_AXES; n++) begin : g_dir
            if (n < mis_pkg::LATHE_AXES) begin : g_lathe
                assign plus_blk[n] = (dir_apply & dplus_s[n])
                    | (lathe_apply & lathe_s[mis_pkg::LATHE_BASE + 2*n]);
                assign minus_blk[n] = (dir_apply & dminus_s[n])
                    | (lathe_apply & lathe_s[mis_pkg::LATHE_BASE + 2*n + 1]);
            end else begin : g_mill
                assign plus_blk[n] = dir_apply & dplus_s[n];
                assign minus_blk[n] = dir_apply & dminus_s[n];
            end
        end
    endgenerate

    wire any_ilk = glob_ilk | (|axis_ilk) | (|plus_blk) | (|minus_blk);

    // ==========================================================
    // Manual override.
    wire ovr_zero = (ovr_s == mis_pkg::OVR_ALL1) | (ovr_s == mis_pkg::OVR_ALL0);
    wire [15:0] ovr_val = ovr_zero ? 16'h0000 : ~ovr_s;
    wire ovr_ok = manual ? ~ovr_zero : ~ext_diag_i[mis_pkg::DG_FOVR0];

    // ==========================================================
    // Motion permission.
    wire motion_mode = mode_valid & ~mode_oh[mis_pkg::MD_EDIT];
    wire base_ok = ~esp_act & ~reset_act & motion_mode & ~glob_ilk & ovr_ok;
    wire [NUM_AXES-1:0] next_plus = {NUM_AXES{base_ok}} & ~axis_ilk & ~plus_blk;
    wire [NUM_AXES-1:0] next_minus = {NUM_AXES{base_ok}} & ~axis_ilk & ~minus_blk;

    // ==========================================================
    // In-position check.
    logic [NUM_AXES-1:0] not_inpos;

    generate
        for (genvar n = 0; n < NUM_AXES; n++) begin : g_inpos
            assign not_inpos[n] = pos_err_i[n*16 +: 16] > inpw;
        end
    endgenerate

    // ==========================================================
    // Diagnostics.
    logic [15:0] next_diag;

    always_comb begin
        next_diag = ext_diag_i & mis_pkg::DG_EXT_MASK;
        next_diag[mis_pkg::DG_INPOS] = |not_inpos;
        next_diag[mis_pkg::DG_ILK] = any_ilk | ext_diag_i[mis_pkg::DG_ILK];
        next_diag[mis_pkg::DG_JOVR0] = ovr_zero;
        next_diag[mis_pkg::DG_RSTW] = wait_rel;
    end

    // ==========================================================
    // Registered status outputs.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            emergency_status_indication_o <= 1'b0;
            reset_status_o <= 1'b0;
            rewind_request_o <= 1'b0;
            mode_disp_o <= 5'h00;
            permit_plus_o <= '0;
            permit_minus_o <= '0;
            diag_o <= 16'h0000;
            manual_override_o <= 16'h0000;
        end else begin
            emergency_status_indication_o <= esp_act;
            reset_status_o <= reset_act;
            rewind_request_o <= rrw_act;
            mode_disp_o <= mode_oh;
            permit_plus_o <= next_plus;
            permit_minus_o <= next_minus;
            diag_o <= next_diag;
            manual_override_o <= ovr_val;
        end
    end

    // ==========================================================
    // Machine coordinates.
    mis_axis_if #(.N(NUM_AXES)) axif ();

    wire [NUM_AXES-1:0] perm_dir = (move_plus_i & permit_plus_o) | (~move_plus_i & permit_minus_o);
    assign axif.step = move_req_i & perm_dir;
    assign axif.plus = move_plus_i;
    assign axif.lock = {NUM_AXES{mlk_s}} | per_axis_machine_lock_s;

    mis_axis_coord #(.N(NUM_AXES)) u_coord (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ax(axif.axis)
    );

    // ==========================================================
    // Wishbone slave: one wait state, ack for one cycle.
    wire req = cyc_i & stb_i & ~ack_o;
    wire wr = req & we_i;
    wire hit_cfg = adr_i == mis_pkg::ADDR_CFG;
    wire hit_ctl = adr_i == mis_pkg::ADDR_CTL;
    wire hit_stat = adr_i == mis_pkg::ADDR_STAT;
    wire hit_diag = adr_i == mis_pkg::ADDR_DIAG;
    wire hit_ovr = adr_i == mis_pkg::ADDR_OVR;
    wire hit_inpw = adr_i == mis_pkg::ADDR_INPW;
    wire [2:0] coord_idx = {1'b0, adr_i[3:2]};
    wire hit_coord = (adr_i[7:4] == mis_pkg::ADDR_COORD[7:4]) && (adr_i[1:0] == 2'h0)
        && (int'(coord_idx) < NUM_AXES);
    wire [3:0] plus_word = 4'(permit_plus_o);
    wire [3:0] minus_word = 4'(permit_minus_o);
    wire [15:0] stat_word = {minus_word, plus_word, mode_disp_o,
        rewind_request_o, reset_status_o, emergency_status_indication_o};
    wire [31:0] rd_mux = hit_cfg ? {24'h000000, cfg}
        : hit_ctl ? {24'h000000, ctl}
        : hit_stat ? {16'h0000, stat_word}
        : hit_diag ? {16'h0000, diag_o}
        : hit_ovr ? {16'h0000, manual_override_o}
        : hit_inpw ? {16'h0000, inpw}
        : hit_coord ? {16'h0000, axif.coord[adr_i[3:2]]}
        : 32'h00000000;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h00000000;
        end else begin
            ack_o <= req;
            dat_o <= req ? rd_mux : 32'h00000000;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg <= mis_pkg::CFG_RST;
            ctl <= mis_pkg::CTL_RST;
            inpw <= mis_pkg::INPW_RST;
        end else begin
            if (wr && hit_cfg && sel_i[0]) begin
                cfg <= dat_i[7:0];
            end
            if (wr && hit_ctl && sel_i[0]) begin
                ctl <= dat_i[7:0] & 8'h03;
            end
            if (wr && hit_inpw && sel_i[0]) begin
                inpw[7:0] <= dat_i[7:0];
            end
            if (wr && hit_inpw && sel_i[1]) begin
                inpw[15:8] <= dat_i[15:8];
            end
        end
    end

    // ==========================================================
    // Checks.
    sequence s_req;
        cyc_i && stb_i && !ack_o;
    endsequence

    sequence s_ack_once;
        ack_o ##1 !ack_o;
    endsequence

    AST_WB_ACK: assert property (@(posedge clk_i) disable iff (rst_i)
        s_req |=> s_ack_once)
        else $error("ack not given for exactly one cycle");

    AST_ESP_INHIBIT: assert property (@(posedge clk_i) disable iff (rst_i)
        esp_act |=> (permit_plus_o == '0) && (permit_minus_o == '0))
        else $error("motion permitted under emergency stop");

    AST_EMG_STATUS: assert property (@(posedge clk_i) disable iff (rst_i)
        esp_act |=> emergency_status_indication_o)
        else $error("emergency status missing");

    AST_RESET_STATUS: assert property (@(posedge clk_i) disable iff (rst_i)
        reset_act |=> reset_status_o && (permit_plus_o == '0))
        else $error("reset status missing or motion permitted");

    AST_REWIND: assert property (@(posedge clk_i) disable iff (rst_i)
        rrw_act |=> rewind_request_o && reset_status_o)
        else $error("rewind request missing");

    AST_MODE_NONE: assert property (@(posedge clk_i) disable iff (rst_i)
        !mode_valid |=> (mode_disp_o == 5'h00) && (permit_plus_o == '0))
        else $error("undefined mode shown or permitted");

    AST_GLOBAL_ILK: assert property (@(posedge clk_i) disable iff (rst_i)
        glob_ilk |=> (permit_plus_o == '0) && (permit_minus_o == '0) && diag_o[mis_pkg::DG_ILK])
        else $error("global interlock not honoured");

    AST_OVR_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
        ovr_zero |=> diag_o[mis_pkg::DG_JOVR0] && (manual_override_o == 16'h0000))
        else $error("zero override not flagged");

    AST_OVR_VALUE: assert property (@(posedge clk_i) disable iff (rst_i)
        !ovr_zero |=> manual_override_o == ~$past(ovr_s))
        else $error("override value wrong");

    AST_RSTW_CLEAR: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(wait_rel) |=> !diag_o[mis_pkg::DG_RSTW])
        else $error("reset wait flag stuck");

    AST_INPOS: assert property (@(posedge clk_i) disable iff (rst_i)
        (|not_inpos) |=> diag_o[mis_pkg::DG_INPOS])
        else $error("in-position flag missing");

endmodule

`default_nettype wire

// ---- src/mis_pkg.sv ----
// Package with offsets, field positions, reset values and codes of the motion inhibit logic.
`default_nettype none

package mis_pkg;

    // ==========================================================
    // Geometry.
    localparam int AXES = 4;
    localparam int COORD_W = 16;
    localparam int OVR_W = 16;

    // ==========================================================
    // Bit positions in the sequence controller control byte.
    localparam int BIT_IT = 0;
    localparam int BIT_ESP = 4;
    localparam int BIT_RRW = 6;
    localparam int BIT_ERS = 7;

    // ==========================================================
    // Interlock configuration fields.
    localparam int CFG_ITL = 0;
    localparam int CFG_ITX = 2;
    localparam int CFG_DIT = 3;
    localparam int CFG_DAU = 4;

    // ==========================================================
    // Control register fields.
    localparam int CTL_LATHE = 0;
    localparam int CTL_RKEY = 1;

    // ==========================================================
    // Lathe direction interlock byte: plus of axis n at 2+2n, minus at 3+2n.
    localparam int LATHE_BASE = 2;
    localparam int LATHE_AXES = 2;

    // ==========================================================
    // Register byte addresses.
    localparam logic [7:0] ADDR_CFG = 8'h00;
    localparam logic [7:0] ADDR_CTL = 8'h04;
    localparam logic [7:0] ADDR_STAT = 8'h08;
    localparam logic [7:0] ADDR_DIAG = 8'h0c;
    localparam logic [7:0] ADDR_OVR = 8'h10;
    localparam logic [7:0] ADDR_INPW = 8'h14;
    localparam logic [7:0] ADDR_COORD = 8'h20;

    // ==========================================================
    // Reset values.
    localparam logic [7:0] CFG_RST = 8'h00;
    localparam logic [7:0] CTL_RST = 8'h00;
    localparam logic [15:0] INPW_RST = 16'h0010;

    // ==========================================================
    // Mode select codes and one-hot display positions.
    localparam logic [2:0] MODE_JOG = 3'h5;
    localparam logic [2:0] MODE_HND = 3'h4;
    localparam logic [2:0] MODE_MDI = 3'h0;
    localparam logic [2:0] MODE_MEM = 3'h1;
    localparam logic [2:0] MODE_EDIT = 3'h3;
    localparam int MD_JOG = 0;
    localparam int MD_HND = 1;
    localparam int MD_MDI = 2;
    localparam int MD_MEM = 3;
    localparam int MD_EDIT = 4;

    // ==========================================================
    // Status register fields.
    localparam int ST_EMG = 0;
    localparam int ST_RST = 1;
    localparam int ST_RWD = 2;
    localparam int ST_MODE = 3;
    localparam int ST_PLUS = 8;
    localparam int ST_MINUS = 12;

    // ==========================================================
    // Diagnostic flag positions, numbered as the diagnostic numbers.
    localparam int DG_INPOS = 3;
    localparam int DG_FOVR0 = 4;
    localparam int DG_ILK = 5;
    localparam int DG_JOVR0 = 13;
    localparam int DG_RSTW = 14;
    localparam logic [15:0] DG_EXT_MASK = 16'h9c77;

    // ==========================================================
    // Manual override codes meaning zero.
    localparam logic [15:0] OVR_ALL1 = 16'hffff;
    localparam logic [15:0] OVR_ALL0 = 16'h0000;

endpackage

`default_nettype wire

// ---- src/mis_axis_if.sv ----
// Interface carrying axis steps, locks and coordinates between the modules.
`default_nettype none

interface mis_axis_if #(
    parameter int N = mis_pkg::AXES
);
    logic [N-1:0] step;
    logic [N-1:0] plus;
    logic [N-1:0] lock;
    logic [N-1:0][mis_pkg::COORD_W-1:0] coord;

    modport ctrl (output step, output plus, output lock, input coord);
    modport axis (input step, input plus, input lock, output coord);
endinterface

`default_nettype wire

// ---- src/mis_axis_coord.sv ----
// Machine coordinate counters, one per axis, frozen while the axis is locked.
`default_nettype none

module mis_axis_coord #(
    parameter int N = mis_pkg::AXES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    mis_axis_if.axis ax
);

    // ==========================================================
    // Counters.
    logic [N-1:0][mis_pkg::COORD_W-1:0] coord;
    logic [N-1:0] adv;
    localparam logic [mis_pkg::COORD_W-1:0] UNIT = {{(mis_pkg::COORD_W-1){1'b0}}, 1'b1};

    generate
        if (N < 1) begin : g_bad
            $error("mis_axis_coord needs at least one axis");
        end
        for (genvar n = 0; n < N; n++) begin : g_ax
            assign adv[n] = ax.step[n] & ~ax.lock[n];
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    coord[n] <= '0;
                end else if (adv[n]) begin
                    coord[n] <= ax.plus[n] ? coord[n] + UNIT : coord[n] - UNIT;
                end
            end

            AST_LOCK_FREEZE: assert property (@(posedge clk_i) disable iff (rst_i)
                ax.lock[n] |=> $stable(coord[n]))
                else $error("locked axis coordinate moved");
        end
    endgenerate

    assign ax.coord = coord;

endmodule

`default_nettype wire

// ---- sim/mis_seq_model.sv ----
// Sequence controller model that drives the machine-side control pins.
`default_nettype none

module mis_seq_model (
    input wire logic clk_i,
    output logic [7:0] ctl_o,
    output logic [2:0] mode_o,
    output logic [3:0] ilk_n_o,
    output logic [3:0] plus_o,
    output logic [3:0] minus_o,
    output logic [7:0] lathe_o,
    output logic [15:0] ovr_n_o,
    output logic mlk_o,
    output logic [3:0] mlk_ax_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // Jog, handwheel, data input, memory, edit, then codes that select nothing.
    localparam logic [2:0] CODE [8] = '{3'h5, 3'h4, 3'h0, 3'h1, 3'h3, 3'h2, 3'h6, 3'h7};

    initial begin
        ctl_o = 8'h11;
        mode_o = CODE[0];
        ilk_n_o = 4'hf;
        plus_o = 4'h0;
        minus_o = 4'h0;
        lathe_o = 8'h00;
        ovr_n_o = 16'hd8ef;
        mlk_o = 1'b0;
        mlk_ax_o = 4'h0;
    end

    // ==========================================================
    // Pin changes, each launched just after a rising edge.
    task automatic put_ctl(input logic [7:0] b);
        @(posedge clk_i);
        ctl_o <= b;
    endtask
    task automatic put_mode(input int i);
        @(posedge clk_i);
        mode_o <= CODE[i];
    endtask
    task automatic put_ilk(input logic [3:0] n, input logic [3:0] p, input logic [3:0] m,
                           input logic [7:0] l);
        @(posedge clk_i);
        ilk_n_o <= n;
        plus_o <= p;
        minus_o <= m;
        lathe_o <= l;
    endtask
    task automatic put_ovr(input logic [15:0] v);
        @(posedge clk_i);
        ovr_n_o <= v;
    endtask
    task automatic put_lock(input logic a, input logic [3:0] p);
        @(posedge clk_i);
        mlk_o <= a;
        mlk_ax_o <= p;
    endtask
endmodule

`default_nettype wire

// ---- sim/tb_top.sv ----
// Self-checking testbench of the motion inhibit logic.
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] adr_i;
    logic [31:0] dat_i;
    logic we_i, cyc_i, stb_i;
    logic [3:0] sel_i;
    logic [15:0] ext_diag_i;
    logic [63:0] pos_err_i;
    logic [3:0] move_req_i, move_plus_i;
    logic [31:0] dat_o;
    logic ack_o, emergency_status_indication_o, reset_status_o, rewind_request_o;
    logic all_axis_machine_lock_i;
    logic [2:0] mode_sel_i;
    logic [4:0] mode_disp_o;
    logic [3:0] axis_interlock_n_i, dir_interlock_plus_i, dir_interlock_minus_i;
    logic [3:0] per_axis_machine_lock_i, permit_plus_o, permit_minus_o;
    logic [7:0] ctl_byte_i, lathe_interlock_i;
    logic [15:0] manual_override_n_i, diag_o, manual_override_o;
    logic [15:0] ovr_n [5] = '{16'hd8ef, 16'h0001, 16'hfffe, 16'hffff, 16'h0000};
    logic [15:0] ovr_e [5] = '{16'h2710, 16'hfffe, 16'h0001, 16'h0000, 16'h0000};
    int err_total = 0;
    int compares = 0;

    always #20 clk_i = ~clk_i;

    mis_motion_inhibit #(.NUM_AXES(4)) u_mis_motion_inhibit (
        .clk_i, .rst_i, .adr_i, .dat_i, .dat_o, .we_i, .sel_i, .cyc_i, .stb_i, .ack_o,
        .ctl_byte_i, .mode_sel_i, .axis_interlock_n_i, .dir_interlock_plus_i,
        .dir_interlock_minus_i, .lathe_interlock_i, .manual_override_n_i,
        .all_axis_machine_lock_i, .per_axis_machine_lock_i, .ext_diag_i, .pos_err_i,
        .move_req_i, .move_plus_i, .emergency_status_indication_o, .reset_status_o,
        .rewind_request_o, .mode_disp_o, .permit_plus_o, .permit_minus_o, .diag_o,
        .manual_override_o);

    mis_seq_model u_mis_seq_model (
        .clk_i, .ctl_o(ctl_byte_i), .mode_o(mode_sel_i), .ilk_n_o(axis_interlock_n_i),
        .plus_o(dir_interlock_plus_i), .minus_o(dir_interlock_minus_i),
        .lathe_o(lathe_interlock_i), .ovr_n_o(manual_override_n_i),
        .mlk_o(all_axis_machine_lock_i), .mlk_ax_o(per_axis_machine_lock_i));

    // ==========================================================
    // Comparison, bus and pacing tasks.
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cp(input logic [3:0] p, input logic [3:0] m);
        chk("permit_plus", 32'(p), 32'(permit_plus_o));
        chk("permit_minus", 32'(m), 32'(permit_minus_o));
    endtask
    // Waits out the two synchroniser stages and the output register.
    task automatic st();
        repeat (4) @(posedge clk_i);
        #1;
    endtask
    task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d,
                      input logic [3:0] s, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        adr_i <= a;
        we_i <= w;
        dat_i <= d;
        sel_i <= s;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 100);
        if (n >= 100) err_total++;
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
        @(posedge clk_i);
        #1;
    endtask
    task automatic wrl(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        logic [31:0] q;
        wb(a, 1'b1, d, s, q);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wrl(a, d, 4'hf);
    endtask
    task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        wb(a, 1'b0, 32'h0, 4'hf, q);
        chk(nm, e, q);
    endtask
    task automatic step(input logic [3:0] m, input logic [3:0] dir);
        @(posedge clk_i);
        move_req_i <= m;
        move_plus_i <= dir;
        @(posedge clk_i);
        move_req_i <= 4'h0;
        st();
    endtask
    task automatic complete_run();
        $display("Counts: %0d compares, %0d mismatches", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk_i);
        err_total++;
        complete_run();
    end

    // ==========================================================
    // Test sequence.
    initial begin
        adr_i <= 8'h00;
        dat_i <= 32'h0;
        {we_i, cyc_i, stb_i} <= 3'h0;
        sel_i <= 4'h0;
        ext_diag_i <= 16'h0;
        pos_err_i <= 64'h0;
        move_req_i <= 4'h0;
        move_plus_i <= 4'hf;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        st();
        rd("cfg", 8'h00, 32'(mis_pkg::CFG_RST));
        rd("ctl", 8'h04, 32'(mis_pkg::CTL_RST));
        rd("inpw", 8'h14, 32'(mis_pkg::INPW_RST));
        wrl(8'h14, 32'h1234, 4'h1);
        rd("inpw_lane0", 8'h14, 32'h34);
        wr(8'h14, 32'(mis_pkg::INPW_RST));
        wr(8'h30, 32'hffffffff);
        rd("unmapped", 8'h30, 32'h0);
        wr(8'h00, 32'h1d);
        rd("cfg", 8'h00, 32'h1d);
        wr(8'h00, 32'h0);
        $display("done: registers");
        for (int i = 0; i < 8; i++) begin
            u_mis_seq_model.put_mode(i);
            st();
            chk("mode", (i < 5) ? 32'h1 << i : 32'h0, 32'(mode_disp_o));
            cp({4{i < 4}}, {4{i < 4}});
        end
        u_mis_seq_model.put_mode(0);
        u_mis_seq_model.put_ctl(8'h01);
        st();
        chk("emg", 32'h1, 32'(emergency_status_indication_o));
        cp(4'h0, 4'h0);
        chk("diag14", 32'h1, 32'(diag_o[mis_pkg::DG_RSTW]));
        rd("status", 8'h08, 32'h9);
        u_mis_seq_model.put_ctl(8'h91);
        st();
        chk("reset", 32'h1, 32'(reset_status_o));
        chk("rewind", 32'h0, 32'(rewind_request_o));
        cp(4'h0, 4'h0);
        chk("diag14", 32'h1, 32'(diag_o[mis_pkg::DG_RSTW]));
        u_mis_seq_model.put_ctl(8'h51);
        st();
        chk("reset", 32'h1, 32'(reset_status_o));
        chk("rewind", 32'h1, 32'(rewind_request_o));
        u_mis_seq_model.put_ctl(8'h11);
        wr(8'h04, 32'h2);
        st();
        chk("reset", 32'h1, 32'(reset_status_o));
        chk("diag14", 32'h0, 32'(diag_o[mis_pkg::DG_RSTW]));
        wr(8'h04, 32'h0);
        $display("done: stop and reset");
        u_mis_seq_model.put_ctl(8'h10);
        st();
        cp(4'h0, 4'h0);
        chk("diag5", 32'h1, 32'(diag_o[mis_pkg::DG_ILK]));
        wr(8'h00, 32'h1);
        st();
        cp(4'hf, 4'hf);
        wr(8'h00, 32'h0);
        u_mis_seq_model.put_ctl(8'h11);
        u_mis_seq_model.put_ilk(4'he, 4'h2, 4'h8, 8'h00);
        st();
        cp(4'hc, 4'h6);
        wr(8'h00, 32'h4);
        st();
        cp(4'hd, 4'h7);
        wr(8'h00, 32'hc);
        st();
        cp(4'hf, 4'hf);
        wr(8'h00, 32'h0);
        u_mis_seq_model.put_mode(3);
        st();
        cp(4'he, 4'he);
        wr(8'h00, 32'h10);
        st();
        cp(4'hc, 4'h6);
        wr(8'h00, 32'h0);
        wr(8'h04, 32'h1);
        u_mis_seq_model.put_ilk(4'hf, 4'hf, 4'hf, 8'h14);
        st();
        cp(4'hf, 4'hf);
        u_mis_seq_model.put_mode(0);
        st();
        cp(4'hc, 4'hf);
        wr(8'h04, 32'h0);
        u_mis_seq_model.put_ilk(4'hf, 4'h0, 4'h0, 8'h00);
        $display("done: interlocks");
        foreach (ovr_n[i]) begin
            u_mis_seq_model.put_ovr(ovr_n[i]);
            st();
            chk("override", 32'(ovr_e[i]), 32'(manual_override_o));
            chk("diag13", 32'(ovr_e[i] == 16'h0), 32'(diag_o[mis_pkg::DG_JOVR0]));
            cp({4{ovr_e[i] != 16'h0}}, {4{ovr_e[i] != 16'h0}});
        end
        u_mis_seq_model.put_ovr(16'hd8ef);
        st();
        rd("override", 8'h10, 32'h2710);
        @(posedge clk_i);
        pos_err_i <= 64'h0000_0000_0011_0000;
        st();
        chk("diag3", 32'h1, 32'(diag_o[mis_pkg::DG_INPOS]));
        @(posedge clk_i);
        pos_err_i <= 64'h0000_0000_0010_0000;
        ext_diag_i <= 16'hffef;
        st();
        chk("diag3", 32'h0, 32'(diag_o[mis_pkg::DG_INPOS]));
        chk("diag_ext", 32'(16'hffef & mis_pkg::DG_EXT_MASK),
            32'(diag_o & mis_pkg::DG_EXT_MASK));
        @(posedge clk_i);
        ext_diag_i <= 16'h0;
        $display("done: override and diagnostics");
        step(4'h3, 4'hf);
        rd("coord0", 8'h20, 32'h1);
        u_mis_seq_model.put_lock(1'b0, 4'h1);
        st();
        step(4'h3, 4'hf);
        rd("coord0", 8'h20, 32'h1);
        rd("coord1", 8'h24, 32'h2);
        u_mis_seq_model.put_lock(1'b1, 4'h0);
        st();
        step(4'h3, 4'hf);
        rd("coord1", 8'h24, 32'h2);
        u_mis_seq_model.put_lock(1'b0, 4'h0);
        st();
        step(4'h3, 4'h0);
        rd("coord0", 8'h20, 32'h0);
        rd("coord1", 8'h24, 32'h1);
        $display("done: machine lock");
        complete_run();
    end
endmodule

`default_nettype wire
